// ===== ebs_drive.sv
/*
  Drive end: start/stop brake sequence with torque compensation at
  start, contactor and brake commands, and short floor operation.
  Assumes link inputs come from logic on mclk; settings are static
  during a run; times are in millisecond ticks.
*/
// The strobed register port and the register offsets were decided locally.
`include "ebs_regs.svh"
`default_nettype none

module ebs_drive
  import ebs_pkg::*;
#(
  parameter int TICK_CYCLES = `EBS_TICK_CYCLES
)
(
  input wire logic mclk,
  input wire logic rstn,
  ebs_link_if.drv link,
  input wire logic closed_loop_vector,
  input wire logic [1:0] speed_reference_source,
  input wire logic [7:0] primary_analog_function,
  input wire logic use_option_ch1,
  input wire logic [7:0] option_ch2_function,
  input wire logic [7:0] option_ch3_function,
  input wire logic [7:0] digital_input_function,
  input wire ebs_torque_t primary_analog_input,
  input wire ebs_torque_t option_ch1_input,
  input wire ebs_torque_t option_ch2_input,
  input wire ebs_torque_t option_ch3_input,
  input wire ebs_time_t torque_increase_time,
  input wire ebs_speed_t torque_fade_speed_level,
  input wire ebs_time_t operation_start_delay,
  input wire ebs_time_t start_zero_speed_time,
  input wire ebs_time_t stop_zero_speed_time,
  input wire ebs_time_t brake_open_delay,
  input wire ebs_time_t brake_close_delay,
  input wire ebs_time_t contactor_open_delay,
  input wire logic short_floor_enable,
  input wire ebs_speed_t short_floor_nominal_speed,
  input wire logic [1:0] speed_input_mode,
  input wire ebs_speed_t nominal_speed_reference,
  input wire ebs_speed_t leveling_speed,
  input wire ebs_speed_t ramp_step,
  output var ebs_speed_t speed_out,
  output var ebs_torque_t torque_out
);
  ebs_state_t state;
  logic [31:0] div_cnt;
  logic tick;
  ebs_time_t timer;
  ebs_torque_t latched;
  ebs_torque_t trq_step;
  logic fading;
  logic dir_q;
  logic [31:0] sf_dist;
  logic [31:0] sf_run;
  ebs_speed_t sf_calc_speed;
  ebs_speed_t target;
  logic trq_sel;
  ebs_torque_t trq_src;
  logic use_trq;
  logic stop_req;
  logic multispeed;
  ebs_speed_t nominal;
  ebs_speed_t nom40;

  // ----------------------------------------------------------------
  // tick divider and settings decode
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_cnt <= 32'h0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= (div_cnt == 32'(TICK_CYCLES - 1));
      div_cnt <= (div_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0 : div_cnt + 32'h1;
    end
  end

  // option channels 2 and 3 win: their select ignores the reference source
  always_comb
  begin
    trq_sel = 1'b1;
    trq_src = 12'h000;
    if (option_ch2_function == `EBS_FN_TRQ_OPTION)
      trq_src = option_ch2_input;
    else if (option_ch3_function == `EBS_FN_TRQ_OPTION)
      trq_src = option_ch3_input;
    else if (speed_reference_source != `EBS_SRC_PRIMARY &&
             primary_analog_function == `EBS_FN_TRQ_PRIMARY)
      trq_src = use_option_ch1 ? option_ch1_input
                               : primary_analog_input;
    else
      trq_sel = 1'b0;
  end

  assign use_trq = trq_sel & closed_loop_vector;
  assign multispeed = (speed_input_mode == 2'h0) ||
                      (speed_input_mode == 2'h3);
  assign nominal = multispeed ? short_floor_nominal_speed
                              : nominal_speed_reference;
  assign nom40 = 16'((32'(nominal) * 32'h2) / 32'h5);

  // stop source depends on speed input mode
  always_comb
  begin
    case (speed_input_mode)
      2'h1: stop_req = !link.leveling;
      2'h2: stop_req = (link.speed_ref == 16'h0);
      default: stop_req = !(link.dir_up | link.dir_down);
    endcase
  end

  // ----------------------------------------------------------------
  // torque compensation latch and ramp
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      dir_q <= 1'b0;
      latched <= 12'h000;
      trq_step <= 12'h000;
    end
    else
    begin
      dir_q <= link.dir_up | link.dir_down;
      if ((link.dir_up | link.dir_down) && !dir_q && state == EBS_IDLE)
      begin
        latched <= use_trq ? trq_src : 12'h000;
        trq_step <= (torque_increase_time == 16'h0) ? trq_src :
          12'(32'(trq_src) / 32'(torque_increase_time));
      end
    end
  end

  // up over the increase time, then faded with the same step
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      torque_out <= 12'h000;
      fading <= 1'b0;
    end
    else if (state == EBS_IDLE)
    begin
      torque_out <= 12'h000;
      fading <= 1'b0;
    end
    else if (state == EBS_TRQ_UP && tick)
      torque_out <= (latched - torque_out <= trq_step || trq_step == 12'h0)
        ? latched : torque_out + trq_step;
    else if (state == EBS_ACCEL && speed_out >= torque_fade_speed_level)
      fading <= 1'b1;
    else if (fading && tick)
      torque_out <= (torque_out <= trq_step || trq_step == 12'h0)
        ? 12'h000 : torque_out - trq_step;
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= EBS_IDLE;
      timer <= 16'h0;
      speed_out <= 16'h0;
      target <= 16'h0;
      sf_dist <= 32'h0;
      sf_run <= 32'h0;
      sf_calc_speed <= 16'h0;
      link.contactor_close <= 1'b0;
      link.brake_open <= 1'b0;
      link.output_on <= 1'b0;
    end
    else
    begin
      if (tick)
        timer <= timer + 16'h1;
      case (state)
        EBS_IDLE:
        begin
          timer <= 16'h0;
          if ((link.dir_up | link.dir_down) && link.release_block &&
              link.speed_ref != 16'h0)
          begin
            link.contactor_close <= 1'b1;
            state <= EBS_WAIT_K;
          end
        end
        EBS_WAIT_K:
        begin
          if ((digital_input_function == `EBS_FN_CONTACTOR_ACK)
              ? link.contactor_ack
              : (timer >= operation_start_delay))
          begin
            link.output_on <= 1'b1;
            timer <= 16'h0;
            state <= EBS_TRQ_UP;
          end
        end
        EBS_TRQ_UP:
        begin
          // without compensation the brake opens on its own delay
          if (use_trq ? (torque_out == latched)
                      : (timer >= brake_open_delay))
          begin
            link.brake_open <= 1'b1;
            timer <= 16'h0;
            state <= EBS_START_HOLD;
          end
        end
        EBS_START_HOLD:
        begin
          if (timer >= start_zero_speed_time)
          begin
            target <= link.speed_ref;
            state <= EBS_ACCEL;
          end
        end
        EBS_ACCEL:
        begin
          if (tick)
            speed_out <= (target - speed_out <= ramp_step)
              ? target : speed_out + ramp_step;
          if (link.leveling)
          begin
            if (short_floor_enable == `EBS_SF_ON &&
                speed_out < nominal && (!multispeed || link.nominal_sel))
            begin
              sf_dist <= 32'h0;
              sf_calc_speed <= nominal;
              target <= (speed_out >= nom40) ? speed_out : nom40;
              state <= EBS_SF_CALC;
            end
            else
              state <= EBS_DEC_LEV;
          end
        end
        EBS_SF_CALC:
        begin
          // area under the decel line, one ramp step per mclk cycle
          if (tick && speed_out < target)
            speed_out <= (target - speed_out <= ramp_step)
              ? target : speed_out + ramp_step;
          if (sf_calc_speed > nom40 && ramp_step != 16'h0)
          begin
            sf_dist <= sf_dist + 32'(sf_calc_speed);
            sf_calc_speed <= (sf_calc_speed - nom40 <= ramp_step)
              ? nom40 : sf_calc_speed - ramp_step;
          end
          else if (speed_out == target)
          begin
            sf_run <= 32'h0;
            state <= EBS_SF_HOLD;
          end
        end
        EBS_SF_HOLD:
        begin
          if (tick)
            sf_run <= sf_run + 32'(speed_out);
          if (sf_run >= sf_dist)
            state <= EBS_DEC_LEV;
        end
        EBS_DEC_LEV:
        begin
          if (tick)
            speed_out <= (speed_out <= leveling_speed + ramp_step)
              ? leveling_speed : speed_out - ramp_step;
          if (speed_out == leveling_speed)
            state <= EBS_LEVEL;
        end
        EBS_LEVEL:
        begin
          if (stop_req)
            state <= EBS_DEC_ZERO;
        end
        EBS_DEC_ZERO:
        begin
          if (tick)
            speed_out <= (speed_out <= ramp_step)
              ? 16'h0 : speed_out - ramp_step;
          if (speed_out == 16'h0)
          begin
            timer <= 16'h0;
            state <= EBS_STOP_HOLD;
          end
        end
        EBS_STOP_HOLD:
        begin
          if (timer >= brake_close_delay)
            link.brake_open <= 1'b0;
          if (timer >= stop_zero_speed_time)
          begin
            link.output_on <= 1'b0;
            state <= EBS_WAIT_BLOCK;
          end
        end
        EBS_WAIT_BLOCK:
        begin
          link.brake_open <= 1'b0;
          timer <= 16'h0;
          if (!link.release_block)
            state <= EBS_K_OPEN;
        end
        EBS_K_OPEN:
        begin
          if (timer >= contactor_open_delay)
          begin
            link.contactor_close <= 1'b0;
            state <= EBS_IDLE;
          end
        end
        default:
          state <= EBS_IDLE;
      endcase
    end
  end
endmodule // ebs_drive

`default_nettype wire

// ===== ebs_regs.svh
/*
  Constants for the elevator brake sequencer: controller register
  offsets, field positions, reset values and timing figures.
  Assumes a 100 MHz mclk and inclusion by bare name.
*/
`ifndef EBS_REGS_SVH
`define EBS_REGS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define EBS_CLK_NS 10
`define EBS_TICK_NS 1000000
`define EBS_TICK_CYCLES (`EBS_TICK_NS / `EBS_CLK_NS)

// ----------------------------------------------------------------
// coded settings
// ----------------------------------------------------------------
`define EBS_FN_TRQ_PRIMARY 8'h01
`define EBS_FN_TRQ_OPTION 8'h0e
`define EBS_FN_CONTACTOR_ACK 8'h56
`define EBS_SRC_PRIMARY 2'h1
`define EBS_SF_ON 1'h1

// ----------------------------------------------------------------
// controller registers
// ----------------------------------------------------------------
`define EBS_CMD_OFS 8'h00
`define EBS_SPD_OFS 8'h04
`define EBS_STS_OFS 8'h08
`define EBS_CMD_UP 0
`define EBS_CMD_DOWN 1
`define EBS_CMD_LEVEL 2
`define EBS_CMD_NOMINAL 3
`define EBS_CMD_RESET 4'h0
`define EBS_SPD_RESET 16'h0000

`endif

// ===== ebs_pkg.sv
/*
  Types shared by both ends of the elevator brake sequencer.
  Assumes ebs_regs.svh holds all numeric constants.
*/
`default_nettype none

package ebs_pkg;
  typedef logic [15:0] ebs_speed_t;
  typedef logic [11:0] ebs_torque_t;
  typedef logic [15:0] ebs_time_t;
  typedef enum logic [3:0]
  {
    EBS_IDLE, EBS_WAIT_K, EBS_TRQ_UP, EBS_START_HOLD, EBS_ACCEL,
    EBS_SF_CALC, EBS_SF_HOLD, EBS_DEC_LEV, EBS_LEVEL, EBS_DEC_ZERO,
    EBS_STOP_HOLD, EBS_WAIT_BLOCK, EBS_K_OPEN
  } ebs_state_t;
endpackage

`default_nettype wire

// ===== ebs_link_if.sv
/*
  Link between the elevator controller and the drive sequencer.
  Assumes both ends run on the same mclk.
*/
`default_nettype none

interface ebs_link_if;
  import ebs_pkg::*;
  logic dir_up;
  logic dir_down;
  logic release_block;
  logic leveling;
  logic nominal_sel;
  ebs_speed_t speed_ref;
  logic contactor_ack;
  logic contactor_close;
  logic brake_open;
  logic output_on;
  modport drv (input dir_up, dir_down, release_block, leveling,
    nominal_sel, speed_ref, contactor_ack,
    output contactor_close, brake_open, output_on);
  modport ctl (output dir_up, dir_down, release_block, leveling,
    nominal_sel, speed_ref, contactor_ack,
    input contactor_close, brake_open, output_on);
endinterface

`default_nettype wire

// ===== ebs_ctl.sv
/*
  Controller end: takes orders from software registers and drives
  direction, release, leveling and speed on the link; forwards the
  contactor auxiliary pin as confirmation.
  Assumes a plain register port with read data one cycle later.
*/
`include "ebs_regs.svh"
`default_nettype none

module ebs_ctl
  import ebs_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  ebs_link_if.ctl link,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic contactor_aux
);
  logic [3:0] cmd;
  logic aux_meta;
  logic ran;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      cmd <= `EBS_CMD_RESET;
    else if (wr && addr == `EBS_CMD_OFS)
      cmd <= wdata[3:0];
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      link.speed_ref <= `EBS_SPD_RESET;
    else if (wr && addr == `EBS_SPD_OFS)
      link.speed_ref <= wdata[15:0];
  end

  // unmapped reads return zero
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      rdata <= 32'h0;
    else if (rd)
    begin
      case (addr)
        `EBS_CMD_OFS: rdata <= {28'h0, cmd};
        `EBS_SPD_OFS: rdata <= {16'h0, link.speed_ref};
        `EBS_STS_OFS: rdata <= {28'h0, link.release_block,
          link.output_on, link.brake_open, link.contactor_close};
        default: rdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // link drive
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      link.dir_up <= 1'b0;
      link.dir_down <= 1'b0;
      link.leveling <= 1'b0;
      link.nominal_sel <= 1'b0;
    end
    else
    begin
      link.dir_up <= cmd[`EBS_CMD_UP];
      link.dir_down <= cmd[`EBS_CMD_DOWN];
      link.leveling <= cmd[`EBS_CMD_LEVEL];
      link.nominal_sel <= cmd[`EBS_CMD_NOMINAL];
    end
  end

  // release with direction; block again once the drive output drops
  // and stay blocked until software removes direction, else the trip
  // would restart while direction is still held
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      link.release_block <= 1'b0;
      ran <= 1'b0;
    end
    else if (link.output_on)
      ran <= 1'b1;
    else if (ran)
    begin
      link.release_block <= 1'b0;
      if (!(cmd[`EBS_CMD_UP] | cmd[`EBS_CMD_DOWN]))
        ran <= 1'b0;
    end
    else
      link.release_block <= cmd[`EBS_CMD_UP] | cmd[`EBS_CMD_DOWN];
  end

  // aux pin is asynchronous: two flops before use
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      aux_meta <= 1'b0;
      link.contactor_ack <= 1'b0;
    end
    else
    begin
      aux_meta <= contactor_aux;
      link.contactor_ack <= aux_meta;
    end
  end
endmodule // ebs_ctl

`default_nettype wire

// ===== ebs_monitor.sv
/*
  Checker on the link between the controller end and the drive end.
  Assumes one mclk domain, rstn active low, signals taken from the link.
*/
`default_nettype none

module ebs_monitor
  import ebs_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic dir_up,
  input wire logic dir_down,
  input wire logic release_block,
  input wire ebs_speed_t speed_ref,
  input wire logic contactor_close,
  input wire logic brake_open,
  input wire logic output_on
);
  // ----------------------------------------------------------------
  // link sequencing
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // a complete request closes the contactor on the next edge
  property p_close_req;
    ((dir_up || dir_down) && release_block && speed_ref != 16'h0000
      && !contactor_close) |=> contactor_close;
  endproperty
  a_close_req: assert property (p_close_req)
    else $error("contactor not closed after a full request");
  property p_close_cause;
    $rose(contactor_close) |-> release_block && (dir_up || dir_down);
  endproperty
  a_close_cause: assert property (p_close_cause)
    else $error("contactor closed without direction and release");
  // output only after the contactor has settled a while
  property p_out_late;
    $rose(output_on) |-> contactor_close && $past(contactor_close, 2);
  endproperty
  a_out_late: assert property (p_out_late)
    else $error("output started before contactor settled");
  property p_brake_out;
    brake_open |-> output_on && contactor_close;
  endproperty
  a_brake_out: assert property (p_brake_out)
    else $error("brake open without output");
  // torque ramp or delay takes at least a few cycles with the settings the bench uses
  property p_brake_late;
    $rose(brake_open) |-> $past(output_on, 3);
  endproperty
  a_brake_late: assert property (p_brake_late)
    else $error("brake opened too soon after output");
  property p_brake_first;
    $fell(output_on) |-> !brake_open;
  endproperty
  a_brake_first: assert property (p_brake_first)
    else $error("output shut down with brake open");
  // controller must block within two cycles of shutdown
  property p_block;
    $fell(output_on) |-> ##[1:2] !release_block;
  endproperty
  a_block: assert property (p_block)
    else $error("release not dropped after output shutdown");
  property p_out_close;
    output_on |-> contactor_close;
  endproperty
  a_out_close: assert property (p_out_close)
    else $error("contactor open while output on");
  property p_open_late;
    $fell(contactor_close) |-> !output_on && !$past(output_on, 3);
  endproperty
  a_open_late: assert property (p_open_late)
    else $error("contactor dropped too soon after shutdown");
endmodule // ebs_monitor

`default_nettype wire

// ===== elevator_brake_sequencer_tb.sv
/*
  Self-checking bench for both ends of the brake sequencer.
  Assumes package, link interface and both ends are compiled first.
*/
`include "ebs_regs.svh"
`default_nettype none

module elevator_brake_sequencer_tb
  import ebs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 4;
  typedef struct {logic [2:0] code; int lo; int hi; logic [15:0] v;} ebs_note_t;
  logic mclk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, aux = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [2:0] aux_pipe = 3'h0, prv = 3'h0, cur;
  logic clv = 1'b0, ch1_sel = 1'b0, sf_en = 1'b0, rd_pend = 1'b0;
  logic [1:0] src = 2'h0, mode = 2'h0;
  logic [7:0] fn_p = 8'h00, fn_2 = 8'h00, fn_3 = 8'h00, fn_di = 8'h00;
  ebs_torque_t in_p = 12'h0, in_1 = 12'h0, in_2 = 12'h0, in_3 = 12'h0;
  ebs_torque_t trq_out;
  ebs_time_t t_inc = 16'h4, t_sod = 16'h8, t_szs = 16'h4, t_stz = 16'ha;
  ebs_time_t t_bo = 16'ha, t_bc = 16'h3, t_co = 16'h6;
  ebs_speed_t fade_lvl = 16'h0100, sf_nom = 16'h0a00, nom_ref = 16'h0500;
  ebs_speed_t lev_spd = 16'h0080, step = 16'h0040, spd_out, max_spd = 16'h0;
  int seed = 66, mismatches = 0, n_checks = 0, cyc = 0, last = 0;
  logic [31:0] q_rd[$];
  ebs_note_t q_ev[$];
  ebs_note_t nt;

  // ----------------------------------------------------------------
  // both ends joined by the link
  // ----------------------------------------------------------------
  ebs_link_if link();
  ebs_ctl ebs_ctl_i (.mclk(mclk), .rstn(rstn), .link(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .contactor_aux(aux));
  ebs_drive #(.TICK_CYCLES(TK)) ebs_drive_i (.mclk(mclk), .rstn(rstn),
    .link(link), .closed_loop_vector(clv), .speed_reference_source(src),
    .primary_analog_function(fn_p), .use_option_ch1(ch1_sel),
    .option_ch2_function(fn_2), .option_ch3_function(fn_3),
    .digital_input_function(fn_di), .primary_analog_input(in_p),
    .option_ch1_input(in_1), .option_ch2_input(in_2),
    .option_ch3_input(in_3), .torque_increase_time(t_inc),
    .torque_fade_speed_level(fade_lvl), .operation_start_delay(t_sod),
    .start_zero_speed_time(t_szs), .stop_zero_speed_time(t_stz),
    .brake_open_delay(t_bo), .brake_close_delay(t_bc),
    .contactor_open_delay(t_co), .short_floor_enable(sf_en),
    .short_floor_nominal_speed(sf_nom), .speed_input_mode(mode),
    .nominal_speed_reference(nom_ref), .leveling_speed(lev_spd),
    .ramp_step(step), .speed_out(spd_out), .torque_out(trq_out));
  ebs_monitor ebs_monitor_i (.mclk(mclk), .rstn(rstn),
    .dir_up(link.dir_up), .dir_down(link.dir_down),
    .release_block(link.release_block), .speed_ref(link.speed_ref),
    .contactor_close(link.contactor_close), .brake_open(link.brake_open),
    .output_on(link.output_on));

  always #5 mclk = ~mclk;
  // auxiliary contact follows the coil a few cycles late, like a relay
  always @(posedge mclk)
  begin
    aux_pipe <= {aux_pipe[1:0], link.contactor_close};
    aux <= aux_pipe[2];
  end

  // ----------------------------------------------------------------
  // compares, notes and bus cycles
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [31:0] got, exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_ev(input logic [2:0] got, exp, input int g, lo, hi);
    n_checks++;
    if (got !== exp || g < lo || g > hi)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: edge %b want %b gap %0d", $time, got,
        exp, g);
    end
  endtask
  task automatic note(input logic [2:0] c, input int lo, hi,
    input logic [15:0] v);
    q_ev.push_back('{c, lo, hi, v});
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] d);
    q_rd.push_back(d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
  endtask
  function automatic logic cond(input int w, input logic [15:0] s);
    case (w)
      0: return spd_out === s;
      1: return spd_out >= 16'h0080;
      2: return spd_out === lev_spd;
      3: return link.output_on === 1'b0;
      default: return link.contactor_close === 1'b0;
    endcase
  endfunction
  // bounded wait so a stuck sequence is reported, not hung on
  task automatic wait_until(input int w, input logic [15:0] s);
    for (int i = 0; i < 5000 && cond(w, s) !== 1'b1; i++)
      @(posedge mclk);
    if (cond(w, s) !== 1'b1)
      chk_val(32'(w), 32'hffff, "wait");
  endtask
  task automatic shuffle;
    in_p <= 12'h100 | 12'($random(seed));
    in_1 <= 12'h100 | 12'($random(seed));
    in_2 <= 12'h100 | 12'($random(seed));
    in_3 <= 12'h100 | 12'($random(seed));
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // one full trip: start, travel, leveling, stop
  // ----------------------------------------------------------------
  task automatic run(input int k, md, input logic c, input logic [1:0] sr,
    input logic [7:0] pf, input logic c1, input logic [7:0] f2, f3,
    input logic ack, sf);
    int d_sd, d_bo, d_inc, d_bc, d_co;
    logic [15:0] spd;
    logic [11:0] trq;
    logic [3:0] go;
    d_sd = 8 + k % 2;
    d_bo = 10 + k % 2;
    d_inc = 4 + k % 2;
    d_bc = 3 + k % 3;
    d_co = 6 + k % 2;
    spd = sf ? 16'h0500 : 16'h0300 + 16'(($random(seed) & 3) << 6);
    go = (md == 0 || md == 3) ? 4'b1001 : 4'b0001;
    max_spd = 16'h0;
    @(posedge mclk);
    mode <= 2'(md);
    clv <= c;
    src <= sr;
    fn_p <= pf;
    ch1_sel <= c1;
    fn_2 <= f2;
    fn_3 <= f3;
    fn_di <= ack ? `EBS_FN_CONTACTOR_ACK : 8'h00;
    sf_en <= sf;
    t_sod <= 16'(d_sd);
    t_bo <= 16'(d_bo);
    t_inc <= 16'(d_inc);
    t_bc <= 16'(d_bc);
    t_stz <= 16'(d_bc + 7);
    t_co <= 16'(d_co);
    t_szs <= 16'(4 + k % 2);
    shuffle;
    @(posedge mclk);
    trq = !c ? 12'h0 : f2 == `EBS_FN_TRQ_OPTION ? in_2 :
      f3 == `EBS_FN_TRQ_OPTION ? in_3 :
      (sr != `EBS_SRC_PRIMARY && pf == `EBS_FN_TRQ_PRIMARY) ?
      (c1 ? in_1 : in_p) : 12'h0;
    note(3'b001, 0, 100000, 16'h0);
    note(3'b011, ack ? 2 : (d_sd - 1) * TK,
      ack ? 16 : (d_sd + 1) * TK + 4, 16'h0);
    note(3'b101, trq != 0 ? (d_inc - 1) * TK : (d_bo - 1) * TK,
      trq != 0 ? (d_inc + 2) * TK + 4 : (d_bo + 1) * TK + 4, 16'(trq));
    note(3'b100, 0, 100000, 16'h0);
    note(3'b010, 6 * TK, 8 * TK + 4, sf ? 16'h0200 : spd);
    note(3'b000, (d_co - 1) * TK, (d_co + 1) * TK + 6, 16'h0);
    wreg(`EBS_SPD_OFS, 32'(spd));
    rreg(`EBS_SPD_OFS, 32'(spd));
    wreg(`EBS_CMD_OFS, 32'(go));
    // input moves after the direction edge must not reach the torque
    repeat (4) @(posedge mclk);
    shuffle;
    wait_until(sf ? 1 : 0, spd);
    rreg(`EBS_STS_OFS, 32'hf);
    wreg(`EBS_CMD_OFS, 32'(go | 4'b0100));
    wait_until(2, spd);
    if (md == 1)
      wreg(`EBS_CMD_OFS, 32'(go));
    else if (md == 2)
      wreg(`EBS_SPD_OFS, 32'h0);
    else
      wreg(`EBS_CMD_OFS, 32'h0);
    wait_until(3, spd);
    repeat (3) @(posedge mclk);
    rreg(`EBS_STS_OFS, 32'h1);
    wreg(`EBS_CMD_OFS, 32'h0);
    wait_until(4, spd);
    repeat (8) @(posedge mclk);
    $display("test %0d done", k);
  endtask

  // watcher: read data one cycle after the strobe, link edges in order
  always @(negedge mclk)
  begin
    cyc++;
    if (rd_pend)
      chk_val(rdata, q_rd.pop_front(), "read data");
    rd_pend = rd;
    if (link.output_on && spd_out > max_spd)
      max_spd = spd_out;
    cur = {link.brake_open, link.output_on, link.contactor_close};
    for (int s = 0; s < 3; s++)
      if (cur[s] !== prv[s])
      begin
        if (q_ev.size() == 0)
          q_ev.push_back('{3'h7, 0, 0, 16'h0});
        nt = q_ev.pop_front();
        chk_ev({s[1:0], cur[s]}, nt.code, cyc - last, nt.lo, nt.hi);
        if (nt.code == 3'b101)
          chk_val(32'(trq_out), 32'(nt.v), "start torque");
        if (nt.code == 3'b100)
          chk_val(32'(trq_out), 32'h0, "faded torque");
        if (nt.code == 3'b010)
          chk_val(32'(max_spd), 32'(nt.v), "peak speed");
        last = cyc;
      end
    prv = cur;
  end

  // watchdog well past the few thousand cycles the trips need
  initial
  begin
    #1000000;
    mismatches++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    test_done;
  end

  // main sequence: reset, register map, then seven trips across the modes and sources
  initial
  begin
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    rreg(`EBS_CMD_OFS, 32'h0);
    rreg(`EBS_STS_OFS, 32'h0);
    wreg(8'h0c, 32'hffff_ffff);
    rreg(8'h0c, 32'h0);
    rreg(`EBS_CMD_OFS, 32'h0);
    run(0, 1, 1, 2'h0, 8'h01, 0, 8'h00, 8'h00, 1, 0);
    run(1, 2, 1, 2'h2, 8'h01, 1, 8'h00, 8'h00, 0, 0);
    run(2, 0, 1, 2'h1, 8'h01, 0, 8'h0e, 8'h00, 1, 0);
    run(3, 3, 1, 2'h1, 8'h00, 0, 8'h00, 8'h0e, 0, 0);
    run(4, 1, 1, 2'h1, 8'h01, 0, 8'h00, 8'h00, 1, 0);
    run(5, 2, 0, 2'h0, 8'h01, 0, 8'h0e, 8'h00, 0, 0);
    run(6, 1, 0, 2'h0, 8'h00, 0, 8'h00, 8'h00, 1, 1);
    test_done;
  end
endmodule // elevator_brake_sequencer_tb

`default_nettype wire
